// ### src/scan_trigger_sequencer.sv
// scan trigger sequencer: init, standby, scan, good-read signalling, sleep
// assumes trigger is synchronous to ref_clk and decode result comes from the decoder
//
// Operation
// - init within 10 ms, then standby
// - idle interval elapsed moves standby to sleep
// - 2 ms low trigger wakes sleep to standby
// - led held during 75 ms data transfer
// - standby scan ends within 120 ms
// - wake plus decode within about 120 ms
// - indicators rise only after decode success or at power-up
// - led high at power-up and good read
// - buzzer high, pwm on good read
// - illumination off, then signal and transmit in the same cycle
`timescale 1ns/100ps
module scan_trigger_sequencer
  import scan_seq_pkg::*;
#(
  parameter int unsigned INIT_T = INIT_TICKS,
  parameter int unsigned SCAN_MIN_T = SCAN_MIN_TICKS,
  parameter int unsigned WAKE_MIN_T = WAKE_MIN_TICKS,
  parameter int unsigned XFER_T = XFER_TICKS,
  parameter int unsigned SCAN_MAX_T = SCAN_MAX_TICKS,
  parameter int unsigned SLEEP_T = SLEEP_IDLE_TICKS,
  parameter int unsigned TICK_C = TICK_CYC,
  parameter int unsigned PWM_HALF = PWM_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic trigger_n,
  input wire logic sleepEnable,
  input wire logic decodeOk,
  output logic illumOn,
  output logic xferActive,
  output logic ledOut,
  output logic buzzerOut,
  output logic sleeping,
  output logic ready
);

  // ------------------------------------------------------------
  // tick divider and trigger sampling
  // ------------------------------------------------------------
  logic [15:0] divCnt_r;
  logic tick_r;
  logic [1:0] trigSync_r;
  logic [31:0] lowCnt_r;
  logic trigLow;

  // one-cycle microsecond tick keeps the long counters narrow
  // tick phase runs free, so every count carries up to one tick of slack
  always_ff @(posedge ref_clk) begin
    if (sys_rst || divCnt_r == 16'(TICK_C - 1)) begin
      divCnt_r <= 16'h0000;
    end else begin
      divCnt_r <= divCnt_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    tick_r <= !sys_rst && divCnt_r == 16'(TICK_C - 1);
  end

  // two stages so a glitchy host line never steers the state directly
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      trigSync_r <= 2'h3;
    end else begin
      trigSync_r <= {trigSync_r[0], trigger_n};
    end
  end

  assign trigLow = !trigSync_r[1];

  // low-time counter, saturating, cleared when trigger returns high
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !trigLow) begin
      lowCnt_r <= 32'h0000_0000;
    end else if (tick_r && lowCnt_r != 32'hffff_ffff) begin
      lowCnt_r <= lowCnt_r + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // mode machine
  // ------------------------------------------------------------
  mode_t state_r;
  mode_t state_nxt;
  logic [31:0] tmr_r;
  logic [31:0] idle_r;
  logic powerUp_r;
  logic stateChange;

  assign stateChange = state_nxt != state_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: begin
        // trigger may already be low here; its low count carries into standby
        if (tick_r && tmr_r >= 32'(INIT_T - 1)) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        // power-up flash pins standby, so the trigger is ignored until it ends
        if (powerUp_r) begin
          state_nxt = ST_STANDBY;
        end else if (trigLow && lowCnt_r >= 32'(SCAN_MIN_T)) begin
          state_nxt = ST_SCAN;
        end else if (sleepEnable && idle_r >= 32'(SLEEP_T)) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SCAN: begin
        // scan budget leaves the transfer time inside the overall limit
        if (decodeOk) begin
          state_nxt = ST_SIGNAL;
        end else if (!trigLow || tmr_r >= 32'(SCAN_MAX_T - XFER_T - SCAN_MIN_T)) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_SIGNAL: begin
        if (tick_r && tmr_r >= 32'(XFER_T - 1)) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_SLEEP: begin
        // short low time wakes only; scan qualification follows in standby
        if (lowCnt_r >= 32'(WAKE_MIN_T)) begin
          state_nxt = ST_STANDBY;
        end
      end
      default: begin
        state_nxt = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // state timer in ticks, restarted on every mode change
  always_ff @(posedge ref_clk) begin
    if (sys_rst || stateChange) begin
      tmr_r <= 32'h0000_0000;
    end else if (tick_r) begin
      tmr_r <= tmr_r + 32'h0000_0001;
    end
  end

  // inactivity timer: any low trigger counts as activity
  // limitation: the trigger is the only activity source this block can see
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_r != ST_STANDBY || trigLow) begin
      idle_r <= 32'h0000_0000;
    end else if (tick_r && idle_r != 32'hffff_ffff) begin
      idle_r <= idle_r + 32'h0000_0001;
    end
  end

  // power-up indication pulse: one transfer-length flash after init
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      powerUp_r <= 1'b0;
    end else if (state_r == ST_INIT && state_nxt == ST_STANDBY) begin
      powerUp_r <= 1'b1;
    end else if (state_r == ST_STANDBY && tick_r && tmr_r >= 32'(XFER_T - 1)) begin
      powerUp_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // indicator outputs
  // ------------------------------------------------------------
  logic [31:0] pwmCnt_r;
  logic pwmLvl_r;

  // square wave for the buzzer during a good read
  // level restarts high so every good read opens with the buzzer on
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_r != ST_SIGNAL || pwmCnt_r == 32'(PWM_HALF - 1)) begin
      pwmCnt_r <= 32'h0000_0000;
    end else begin
      pwmCnt_r <= pwmCnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_r != ST_SIGNAL) begin
      pwmLvl_r <= 1'b1;
    end else if (pwmCnt_r == 32'(PWM_HALF - 1)) begin
      pwmLvl_r <= !pwmLvl_r;
    end
  end

  // illumination drops the moment decode succeeds, before indicators rise
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      illumOn <= 1'b0;
      xferActive <= 1'b0;
      ledOut <= RST_LED;
      buzzerOut <= RST_BUZ;
      sleeping <= 1'b0;
      ready <= 1'b0;
    end else begin
      illumOn <= state_nxt == ST_SCAN;
      xferActive <= state_r == ST_SIGNAL;
      ledOut <= state_r == ST_SIGNAL || powerUp_r;
      buzzerOut <= (state_r == ST_SIGNAL && pwmLvl_r) || powerUp_r;
      sleeping <= state_r == ST_SLEEP;
      ready <= state_r == ST_STANDBY;
    end
  end

endmodule : scan_trigger_sequencer

// ### src/scan_seq_pkg.sv
// package for the scan trigger sequencer: mode states and timing constants
// assumes a single 200 MHz clock; TICK_CYC derives from the rate below
package scan_seq_pkg;

  // ------------------------------------------------------------
  // clock rate
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;

  // ------------------------------------------------------------
  // times as printed, in microseconds
  // ------------------------------------------------------------
  localparam int unsigned INIT_MAX_US = 10_000;
  localparam int unsigned SCAN_MIN_US = 20_000;
  localparam int unsigned WAKE_MIN_US = 2_000;
  localparam int unsigned XFER_US = 75_000;
  localparam int unsigned SCAN_MAX_US = 120_000;
  localparam int unsigned TICK_US = 1;

  // ------------------------------------------------------------
  // derived cycle counts: one microsecond tick, rest counted in ticks except PWM_HALF_CYC in cycles
  // ------------------------------------------------------------
  localparam int unsigned TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned INIT_TICKS = INIT_MAX_US / TICK_US;
  localparam int unsigned SCAN_MIN_TICKS = (SCAN_MIN_US + TICK_US - 1) / TICK_US;
  localparam int unsigned WAKE_MIN_TICKS = (WAKE_MIN_US + TICK_US - 1) / TICK_US;
  localparam int unsigned XFER_TICKS = XFER_US / TICK_US;
  localparam int unsigned SCAN_MAX_TICKS = SCAN_MAX_US / TICK_US;
  localparam int unsigned SLEEP_IDLE_TICKS = 1_000_000;
  localparam int unsigned PWM_HALF_CYC = 50_000;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic RST_LED = 1'b0;
  localparam logic RST_BUZ = 1'b0;

  // engine modes
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_STANDBY = 3'b001,
    ST_SCAN = 3'b010,
    ST_SIGNAL = 3'b011,
    ST_SLEEP = 3'b100
  } mode_t;

endpackage : scan_seq_pkg

// ### sim/scan_seq_checker.sv
// checker for the scan trigger sequencer, top ports only
// assumes one clock, sync active high reset, shortened counts
`timescale 1ns/100ps
module scan_seq_checker
  import scan_seq_pkg::*;
#(
  parameter int unsigned INIT_T = 10,
  parameter int unsigned XFER_T = 75,
  parameter int unsigned SCAN_MIN_T = 20,
  parameter int unsigned SCAN_MAX_T = 120,
  parameter int unsigned TICK_C = 2
) (
  input wire logic ref_clk, input wire logic sys_rst, input wire logic trigger_n,
  input wire logic sleepEnable, input wire logic decodeOk, input wire logic illumOn,
  input wire logic xferActive, input wire logic ledOut, input wire logic buzzerOut,
  input wire logic sleeping, input wire logic ready
);
  // margins cover the sync flops and tick phase
  localparam int INIT_LIM = INIT_T * TICK_C + 8;
  localparam int SCAN_LIM = (SCAN_MAX_T - XFER_T - SCAN_MIN_T) * TICK_C + 4;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_init; $fell(sys_rst) |-> ##[1:INIT_LIM] (ledOut || ready); endproperty
  a_init: assert property (p_init) else $error("init too long");
  property p_lamp; illumOn && decodeOk |=> !illumOn; endproperty
  a_lamp: assert property (p_lamp) else $error("light kept on");
  property p_read; illumOn && decodeOk |=> ##1 (ledOut && xferActive); endproperty
  a_read: assert property (p_read) else $error("no good read");
  property p_hold; xferActive |-> ledOut; endproperty
  a_hold: assert property (p_hold) else $error("led dropped");
  property p_doze; $rose(sleeping) |-> $past(sleepEnable); endproperty
  a_doze: assert property (p_doze) else $error("sleep not allowed");
  property p_pwm; xferActive |-> ##[0:9] !buzzerOut; endproperty
  a_pwm: assert property (p_pwm) else $error("buzzer not toggling");
  property p_tmo; $rose(illumOn) |-> ##[1:SCAN_LIM] !illumOn; endproperty
  a_tmo: assert property (p_tmo) else $error("scan too long");
  property p_trig; $rose(illumOn) |-> !$past(trigger_n, 3); endproperty
  a_trig: assert property (p_trig) else $error("scan without trigger");
  c_read: cover property ($rose(xferActive));
  c_doze: cover property ($rose(sleeping));
  c_wake: cover property ($fell(sleeping));
endmodule : scan_seq_checker
bind scan_trigger_sequencer scan_seq_checker #(
  .INIT_T(INIT_T),
  .XFER_T(XFER_T),
  .SCAN_MIN_T(SCAN_MIN_T),
  .SCAN_MAX_T(SCAN_MAX_T),
  .TICK_C(TICK_C)
) i_chk (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .trigger_n(trigger_n),
  .sleepEnable(sleepEnable),
  .decodeOk(decodeOk),
  .illumOn(illumOn),
  .xferActive(xferActive),
  .ledOut(ledOut),
  .buzzerOut(buzzerOut),
  .sleeping(sleeping),
  .ready(ready)
);

// ### sim/scan_host_model.sv
// host model: owns the active low trigger line
// assumes calls come at the falling edge; idle line pulled high
`timescale 1ns/100ps
module scan_host_model (
  input wire logic ref_clk,
  output logic trigger_n
);
  initial trigger_n = 1'b1;
  // low for n cycles, then released to the pull-up level
  task automatic pulse(input int n);
    trigger_n = 1'b0;
    repeat (n) @(negedge ref_clk);
    trigger_n = 1'b1;
  endtask : pulse
  // open ended hold for a whole scan
  task automatic level(input logic v);
    trigger_n = v;
  endtask : level
endmodule : scan_host_model

// ### sim/scan_trigger_sequencer_tb_top.sv
// testbench for the scan trigger sequencer, shortened counts
// assumes checker and host model compiled first
`timescale 1ns/100ps
module scan_trigger_sequencer_tb_top;
  import scan_seq_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, sleepEnable = 1'b0, decodeOk = 1'b0;
  logic trigger_n, illumOn, xferActive, ledOut, buzzerOut, sleeping, ready;
  int error_cnt = 0, num_checks = 0, n;
  // shortened counts keep the whole run to a few hundred cycles
  localparam int unsigned SH_TICK = 2;
  localparam int unsigned SH_INIT = 10;
  localparam int unsigned SH_SCAN_MIN = 20;
  localparam int unsigned SH_WAKE_MIN = 2;
  localparam int unsigned SH_XFER = 75;
  localparam int unsigned SH_SCAN_MAX = 120;
  localparam int unsigned SH_SLEEP = 50;
  localparam int unsigned SH_PWM = 4;
  always #2.5 ref_clk = ~ref_clk;
  scan_host_model i_host (
    .ref_clk(ref_clk),
    .trigger_n(trigger_n)
  );
  scan_trigger_sequencer #(
    .TICK_C(SH_TICK),
    .INIT_T(SH_INIT),
    .SCAN_MIN_T(SH_SCAN_MIN),
    .WAKE_MIN_T(SH_WAKE_MIN),
    .XFER_T(SH_XFER),
    .SCAN_MAX_T(SH_SCAN_MAX),
    .SLEEP_T(SH_SLEEP),
    .PWM_HALF(SH_PWM)
  ) i_dut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .trigger_n(trigger_n),
    .sleepEnable(sleepEnable),
    .decodeOk(decodeOk),
    .illumOn(illumOn),
    .xferActive(xferActive),
    .ledOut(ledOut),
    .buzzerOut(buzzerOut),
    .sleeping(sleeping),
    .ready(ready)
  );
  task automatic chk(input string nm, input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // bounded wait, n keeps the cycles spent
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (n = 0; n < lim && s !== v; n++) @(negedge ref_clk);
  endtask : wait_for
  task automatic t_power();
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    chk("ready", ready, 1'b0);
    wait_for(ledOut, 1'b1, 30);
    chk("led", ledOut, 1'b1);
    chk("buzzer", buzzerOut, 1'b1);
    wait_for(ledOut, 1'b0, 200);
    chk("ready", ready, 1'b1);
  endtask : t_power
  // too short a trigger, decode outside a scan
  task automatic t_short();
    decodeOk = 1'b1;
    i_host.pulse(30);
    decodeOk = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("illumOn", illumOn, 1'b0);
    chk("ledOut", ledOut, 1'b0);
  endtask : t_short
  task automatic t_scan();
    i_host.level(1'b0);
    wait_for(illumOn, 1'b1, 60);
    chk("qualify", n >= 40, 1'b1);
    chk("illumOn", illumOn, 1'b1);
    decodeOk = 1'b1;
    @(negedge ref_clk);
    decodeOk = 1'b0;
    chk("illumOn", illumOn, 1'b0);
    chk("ledOut", ledOut, 1'b0);
    @(negedge ref_clk);
    chk("ledOut", ledOut, 1'b1);
    chk("buzzer on", buzzerOut, 1'b1);
    i_host.level(1'b1);
    repeat (4) @(negedge ref_clk);
    chk("buzzer off", buzzerOut, 1'b0);
    wait_for(xferActive, 1'b0, 200);
    chk("xfer span", n >= 140, 1'b1);
  endtask : t_scan
  // no decode: scan must give up on time
  task automatic t_timeout();
    i_host.level(1'b0);
    wait_for(illumOn, 1'b1, 60);
    wait_for(illumOn, 1'b0, 80);
    chk("timeout", n inside {[44:56]}, 1'b1);
    i_host.level(1'b1);
    chk("ledOut", ledOut, 1'b0);
    wait_for(ready, 1'b1, 20);
    chk("ready", ready, 1'b1);
  endtask : t_timeout
  task automatic t_sleep();
    sleepEnable = 1'b1;
    wait_for(sleeping, 1'b1, 150);
    chk("sleeping", sleeping, 1'b1);
    i_host.pulse(2);
    repeat (6) @(negedge ref_clk);
    chk("sleeping", sleeping, 1'b1);
    i_host.pulse(8);
    wait_for(ready, 1'b1, 10);
    chk("ready", ready, 1'b1);
    sleepEnable = 1'b0;
  endtask : t_sleep
  initial begin
    t_power();
    t_short();
    t_scan();
    t_timeout();
    t_sleep();
    end_sim();
  end
  // run needs a few hundred cycles, so 20 us (4000 cycles) means a hang
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
endmodule : scan_trigger_sequencer_tb_top
